// file: design/adcs_pkg.sv
// adcs_pkg: constants and types for the converter sample/convert sequencer
// assumes a 32-bit apb slave port and a single 200 MHz clock
package adcs_pkg;

    // register byte offsets
    localparam logic [11:0] ADCS_OFF_CTRL   = 12'h000;
    localparam logic [11:0] ADCS_OFF_CFG    = 12'h004;
    localparam logic [11:0] ADCS_OFF_IRQST  = 12'h008;
    localparam logic [11:0] ADCS_OFF_IRQMSK = 12'h00c;
    localparam logic [11:0] ADCS_OFF_STATE  = 12'h010;

    // control register field positions
    localparam int ADCS_B_DONE   = 0;
    localparam int ADCS_B_ACQ    = 1;
    localparam int ADCS_B_AUTO   = 2;
    localparam int ADCS_B_CLRAS  = 4;
    localparam int ADCS_B_TRIG_L = 5;
    localparam int ADCS_B_ON     = 15;

    // irq status bits
    localparam int ADCS_I_DONE = 0;
    localparam int ADCS_I_STOP = 1;

    localparam logic [31:0] ADCS_CTRL_RST = 32'h0000_0000;
    localparam logic [2:0]  ADCS_TRIG_MANUAL = 3'h0;

    // timing: sample and conversion durations in cycles
    localparam int ADCS_ACQ_CYC_DEF  = 16;
    localparam int ADCS_CONV_CYC_DEF = 12;

    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} adcs_state_t;

    typedef struct packed {
        logic       on;
        logic [2:0] trig;
        logic       halt_irq;
        logic       auto_acq;
        logic       acq;
        logic       done;
    } adcs_ctrl_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } adcs_apb_req_t;

endpackage : adcs_pkg

// file: design/adcs_counter.sv
// adcs_counter: reloadable down counter that pulses when it reaches zero
// assumes the caller loads it once per phase
`timescale 1ns/1ps
`default_nettype none
module adcs_counter #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // control
    input  wire logic         load,
    input  wire logic [W-1:0] value,
    // result
    output logic              expired
);
    logic [W-1:0] cnt_q, cnt_d;
    logic         run_q, run_d;
    logic         exp_q, exp_d;

    always_comb
    begin
        cnt_d = cnt_q;
        run_d = run_q;
        exp_d = 1'b0;
        if (load)
        begin
            cnt_d = value;
            run_d = 1'b1;
        end
        else if (run_q)
        begin
            if (cnt_q <= W'(1))
            begin
                run_d = 1'b0;
                exp_d = 1'b1;
            end
            else
                cnt_d = cnt_q - W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= '0;
            run_q <= 1'b0;
            exp_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            run_q <= run_d;
            exp_q <= exp_d;
        end
    end

    assign expired = exp_q;
endmodule : adcs_counter
`default_nettype wire

// file: design/adcs_seq.sv
// adcs_seq: sample/convert sequencer with apb control register and irq
// assumes synchronous trigger input and the analog core timing set by cfg
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module adcs_seq
    import adcs_pkg::*;
#(
    parameter int CNT_W = 8
) (
    // apb slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // hardware trigger
    input  wire logic        hw_trigger,
    // analog core
    output logic             sample_hold,
    output logic             convert_start,
    output logic             result_valid,
    // interrupt
    output logic             irq
);
    import adcs_pkg::*;

    adcs_apb_req_t req;
    assign req = '{psel, penable, pwrite, paddr, pwdata};

    adcs_ctrl_t        ctl_q, ctl_d;
    adcs_state_t       st_q, st_d;
    logic [CNT_W-1:0]  scyc_q, scyc_d, ccyc_q, ccyc_d;
    logic [1:0]        ist_q, ist_d, imsk_q, imsk_d;
    logic [31:0]       rd_q, rd_d;
    logic              rdy_q, rdy_d, err_q, err_d;
    logic              sh_q, sh_d, cs_q, cs_d, rv_q, rv_d, irq_q, irq_d;
    logic              ld_acq, ld_conv, acq_exp, conv_exp;
    logic              wr, rd, ctl_hit;

    adcs_counter #(.W(CNT_W)) u_acq_cnt (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (ld_acq),
        .value   (scyc_q),
        .expired (acq_exp)
    );
    adcs_counter #(.W(CNT_W)) u_conv_cnt (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (ld_conv),
        .value   (ccyc_q),
        .expired (conv_exp)
    );

    // zero-wait slave: setup then one access cycle
    // write lands only at the edge where pready is seen high
    assign wr      = req.psel && req.penable && req.pwrite && rdy_q;
    assign rd      = req.psel && !req.penable;
    assign ctl_hit = (req.paddr == ADCS_OFF_CTRL);

    always_comb
    begin
        logic start_conv;
        logic done_ev;
        start_conv = 1'b0;
        done_ev    = 1'b0;
        ctl_d   = ctl_q;
        st_d    = st_q;
        scyc_d  = scyc_q;
        ccyc_d  = ccyc_q;
        imsk_d  = imsk_q;
        ist_d   = ist_q;
        ld_acq  = 1'b0;
        ld_conv = 1'b0;
        cs_d    = 1'b0;
        rv_d    = 1'b0;
        // software writes
        if (wr)
        begin
            if (ctl_hit)
            begin
                ctl_d.on       = req.pwdata[ADCS_B_ON];
                ctl_d.trig     = req.pwdata[ADCS_B_TRIG_L+2:ADCS_B_TRIG_L];
                ctl_d.halt_irq = req.pwdata[ADCS_B_CLRAS];
                ctl_d.auto_acq = req.pwdata[ADCS_B_AUTO];
                if (!req.pwdata[ADCS_B_DONE])
                    ctl_d.done = 1'b0;
                if (!ctl_q.auto_acq && req.pwdata[ADCS_B_ACQ] && st_q == ST_IDLE && ctl_q.on)
                begin
                    ctl_d.acq = 1'b1;
                    st_d      = ST_SAMPLE;
                    ld_acq    = 1'b1;
                end
                if (st_q == ST_SAMPLE && !req.pwdata[ADCS_B_ACQ]
                    && ctl_q.trig == ADCS_TRIG_MANUAL)
                    start_conv = 1'b1;
            end
            else if (req.paddr == ADCS_OFF_CFG)
            begin
                scyc_d = req.pwdata[CNT_W-1:0];
                ccyc_d = req.pwdata[CNT_W+15:16];
            end
            else if (req.paddr == ADCS_OFF_IRQST)
                ist_d = ist_q & ~req.pwdata[1:0];
            else if (req.paddr == ADCS_OFF_IRQMSK)
                imsk_d = req.pwdata[1:0];
        end
        // sequencer
        case (st_q)
            ST_IDLE:
                if (ctl_q.on && ctl_q.auto_acq)
                begin
                    ctl_d.acq = 1'b1;
                    st_d      = ST_SAMPLE;
                    ld_acq    = 1'b1;
                end
            ST_SAMPLE:
                // automatic end: timer or hardware trigger
                if (ctl_q.trig != ADCS_TRIG_MANUAL && (acq_exp || hw_trigger))
                    start_conv = 1'b1;
            ST_CONVERT:
                if (conv_exp)
                begin
                    done_ev    = 1'b1;
                    rv_d       = 1'b1;
                    ctl_d.done = 1'b1;
                    st_d       = ST_IDLE;
                    if (ctl_q.halt_irq)
                        ctl_d.auto_acq = 1'b0;
                    else if (ctl_d.auto_acq && ctl_q.on)
                    begin
                        ctl_d.acq = 1'b1;
                        st_d      = ST_SAMPLE;
                        ld_acq    = 1'b1;
                    end
                end
            default: st_d = ST_IDLE;
        endcase
        if (start_conv)
        begin
            ctl_d.acq  = 1'b0;
            ctl_d.done = 1'b0;
            st_d       = ST_CONVERT;
            ld_conv    = 1'b1;
            cs_d       = 1'b1;
        end
        // switching off wins: no start pulse the core would never see finish
        if (!ctl_d.on)
        begin
            st_d      = ST_IDLE;
            ctl_d.acq = 1'b0;
            ld_acq    = 1'b0;
            ld_conv   = 1'b0;
            cs_d      = 1'b0;
        end
        // set wins over clear
        if (done_ev)
            ist_d[ADCS_I_DONE] = 1'b1;
        if (done_ev && ctl_q.halt_irq)
            ist_d[ADCS_I_STOP] = 1'b1;
        sh_d  = ctl_d.acq;
        irq_d = |(ist_d & imsk_d);
    end

    // read mux
    always_comb
    begin
        rd_d  = rd_q;
        err_d = 1'b0;
        rdy_d = req.psel && !req.penable;
        if (rd)
        begin
            if (ctl_hit)
            begin
                rd_d = ADCS_CTRL_RST;
                rd_d[ADCS_B_ON]    = ctl_q.on;
                rd_d[ADCS_B_TRIG_L+2:ADCS_B_TRIG_L] = ctl_q.trig;
                rd_d[ADCS_B_CLRAS] = ctl_q.halt_irq;
                rd_d[ADCS_B_AUTO]  = ctl_q.auto_acq;
                rd_d[ADCS_B_ACQ]   = ctl_q.acq;
                rd_d[ADCS_B_DONE]  = ctl_q.done;
            end
            else if (req.paddr == ADCS_OFF_CFG)
            begin
                rd_d = 32'h0;
                rd_d[CNT_W-1:0]   = scyc_q;
                rd_d[CNT_W+15:16] = ccyc_q;
            end
            else if (req.paddr == ADCS_OFF_IRQST)
                rd_d = {30'h0, ist_q};
            else if (req.paddr == ADCS_OFF_IRQMSK)
                rd_d = {30'h0, imsk_q};
            else if (req.paddr == ADCS_OFF_STATE)
                rd_d = {30'h0, st_q};
            else
            begin
                rd_d  = 32'h0;
                err_d = 1'b1;
            end
        end
        else if (!req.psel)
            rd_d = 32'h0;
        else
            err_d = err_q;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctl_q  <= '0;
            st_q   <= ST_IDLE;
            scyc_q <= CNT_W'(ADCS_ACQ_CYC_DEF);
            ccyc_q <= CNT_W'(ADCS_CONV_CYC_DEF);
            ist_q  <= 2'h0;
            imsk_q <= 2'h0;
            rd_q   <= 32'h0;
            rdy_q  <= 1'b0;
            err_q  <= 1'b0;
            sh_q   <= 1'b0;
            cs_q   <= 1'b0;
            rv_q   <= 1'b0;
            irq_q  <= 1'b0;
        end
        else
        begin
            ctl_q  <= ctl_d;
            st_q   <= st_d;
            scyc_q <= scyc_d;
            ccyc_q <= ccyc_d;
            ist_q  <= ist_d;
            imsk_q <= imsk_d;
            rd_q   <= rd_d;
            rdy_q  <= rdy_d;
            err_q  <= err_d;
            sh_q   <= sh_d;
            cs_q   <= cs_d;
            rv_q   <= rv_d;
            irq_q  <= irq_d;
        end
    end

    assign prdata        = rd_q;
    assign pready        = rdy_q;
    assign pslverr       = err_q;
    assign sample_hold   = sh_q;
    assign convert_start = cs_q;
    assign result_valid  = rv_q;
    assign irq           = irq_q;

    // checks
    a_done_sets: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == ST_CONVERT && conv_exp) |=> ctl_q.done)
        else $error("done not set after conversion");
    a_done_clear_conv: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(cs_q) |-> !ctl_q.done)
        else $error("done not cleared at conversion start");
    a_stop_clears_auto: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == ST_CONVERT && conv_exp && ctl_q.halt_irq)
        |=> !ctl_q.auto_acq && st_q == ST_IDLE)
        else $error("auto-start survived first irq");
    a_auto_restart: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == ST_CONVERT && conv_exp && !ctl_q.halt_irq && ctl_q.auto_acq && ctl_q.on
         && !(wr && ctl_hit)) |=> st_q == ST_SAMPLE && sh_q)
        else $error("no automatic resample");
    a_no_self_start: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == ST_IDLE && !ctl_q.auto_acq && !(wr && ctl_hit)) |=> st_q == ST_IDLE)
        else $error("sampling began without software");
    a_manual_end: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == ST_SAMPLE && ctl_q.trig == ADCS_TRIG_MANUAL && ctl_q.on && !wr)
        |=> st_q != ST_CONVERT)
        else $error("manual mode converted without software");
    a_auto_end: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == ST_SAMPLE && ctl_q.trig != ADCS_TRIG_MANUAL && hw_trigger && ctl_q.on
         && !(wr && ctl_hit)) |=> !ctl_q.acq && cs_q && st_q == ST_CONVERT)
        else $error("trigger did not end sampling");
    a_acq_mirror: assert property (@(posedge pclk) disable iff (!presetn)
        sh_q == ctl_q.acq && ctl_q.acq == (st_q == ST_SAMPLE))
        else $error("sample flag and s/h output disagree");
    a_bit3_zero: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(rd) && $past(ctl_hit)) |-> !prdata[3])
        else $error("reserved bit read nonzero");
    a_clear_keeps_conv: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == ST_CONVERT && !conv_exp && wr && ctl_hit && req.pwdata[ADCS_B_ON]
         && !req.pwdata[ADCS_B_DONE]) |=> st_q == ST_CONVERT)
        else $error("clearing done disturbed a conversion");
    a_start_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        cs_q |=> !cs_q)
        else $error("conversion start wider than one cycle");
    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        irq == |(ist_q & imsk_q))
        else $error("irq does not follow status and mask");
endmodule : adcs_seq
`default_nettype wire

// file: dv/adcs_core_model.sv
// adcs_core_model: stand-in for the analog sample/hold and converter core
// assumes the sequencer's pulses are registered on pclk and one cycle wide
`timescale 1ns/1ps
`default_nettype none
module adcs_core_model (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // from sequencer
    input  wire logic       sample_hold,
    input  wire logic       convert_start,
    input  wire logic       result_valid,
    // bench knob: acquisition cycles before the trigger, zero keeps it quiet
    input  wire logic [3:0] trig_after,
    // to sequencer and bench
    output logic            hw_trigger,
    output logic            bad_pair
);
    logic [3:0] acq_q;
    logic       busy_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acq_q      <= 4'h0;
            busy_q     <= 1'b0;
            bad_pair   <= 1'b0;
            hw_trigger <= 1'b0;
        end
        else
        begin
            acq_q      <= sample_hold ? acq_q + 4'h1 : 4'h0;
            hw_trigger <= sample_hold && trig_after != 4'h0 && acq_q == trig_after;
            if (convert_start)
                busy_q <= 1'b1;
            else if (result_valid)
                busy_q <= 1'b0;
            // a finish without a start means the pulses lost their pairing
            if (result_valid && !busy_q)
                bad_pair <= 1'b1;
        end
    end
endmodule : adcs_core_model
`default_nettype wire

// file: dv/adc_sample_convert_control_test.sv
// adc_sample_convert_control_test: apb-driven checks of the sample/convert sequencer
// assumes adcs_seq, adcs_counter and adcs_core_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module adc_sample_convert_control_test;
    import adcs_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic        hw_trigger, sample_hold, convert_start, result_valid, irq, bad_pair;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  trig_after;
    int          errors, n_tests;

    adcs_seq dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hw_trigger(hw_trigger), .sample_hold(sample_hold),
        .convert_start(convert_start), .result_valid(result_valid), .irq(irq));
    adcs_core_model core_u (.pclk(pclk), .presetn(presetn), .sample_hold(sample_hold),
        .convert_start(convert_start), .result_valid(result_valid),
        .trig_after(trig_after), .hw_trigger(hw_trigger), .bad_pair(bad_pair));

    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic give_verdict;
        if (errors == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait for the answer
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // exp tells whether the level must appear within lim edges
    task automatic wait_hi(ref logic s, input int lim, input logic exp);
        int n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (s !== 1'b1 && n < lim);
        chk({31'h0, s === 1'b1}, {31'h0, exp});
    endtask : wait_hi

    initial
    begin
        errors = 0;
        n_tests = 0;
        {presetn, psel, penable, pwrite} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        trig_after = 4'h3;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADCS_OFF_CTRL, 32'h0);
        chk(rd, ADCS_CTRL_RST);
        apb(1'b1, ADCS_OFF_CFG, 32'h0028_00c8);   // 200 sample, 40 convert cycles
        apb(1'b1, ADCS_OFF_IRQMSK, 32'h3);
        apb(1'b1, ADCS_OFF_CTRL, 32'h0000_8008);
        apb(1'b0, ADCS_OFF_CTRL, 32'h0);
        chk(rd, 32'h0000_8000);
        apb(1'b0, 12'h020, 32'h0);
        chk({er, rd[30:0]}, 32'h8000_0000);
        repeat (20) @(posedge pclk);
        chk({31'h0, sample_hold}, 32'h0);
        apb(1'b1, ADCS_OFF_CTRL, 32'h0000_8002);
        wait_hi(sample_hold, 8, 1'b1);
        repeat (10) @(posedge pclk);
        apb(1'b0, ADCS_OFF_CTRL, 32'h0);
        chk(rd, 32'h0000_8002);
        apb(1'b1, ADCS_OFF_CTRL, 32'h0000_8000);
        wait_hi(convert_start, 8, 1'b1);
        apb(1'b0, ADCS_OFF_CTRL, 32'h0);
        chk(rd, 32'h0000_8000);
        apb(1'b1, ADCS_OFF_CTRL, 32'h0000_8000);
        wait_hi(result_valid, 60, 1'b1);
        apb(1'b0, ADCS_OFF_CTRL, 32'h0);
        chk(rd, 32'h0000_8001);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, ADCS_OFF_IRQMSK, 32'h0);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, ADCS_OFF_IRQMSK, 32'h3);
        apb(1'b1, ADCS_OFF_IRQST, 32'h1);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        // done kept at one so the hardware clear at the next start is visible
        apb(1'b1, ADCS_OFF_CTRL, 32'h0000_8025);
        wait_hi(convert_start, 30, 1'b1);
        apb(1'b0, ADCS_OFF_CTRL, 32'h0);
        chk(rd, 32'h0000_8024);
        repeat (3)
        begin
            wait_hi(result_valid, 60, 1'b1);
            wait_hi(sample_hold, 4, 1'b1);
            wait_hi(convert_start, 30, 1'b1);
        end
        trig_after <= 4'h0;
        wait_hi(result_valid, 60, 1'b1);
        wait_hi(sample_hold, 4, 1'b1);
        apb(1'b0, ADCS_OFF_CTRL, 32'h0);
        chk(rd, 32'h0000_8027);
        apb(1'b1, ADCS_OFF_CTRL, 32'h0000_8034);
        trig_after <= 4'h3;
        wait_hi(result_valid, 300, 1'b1);
        wait_hi(convert_start, 60, 1'b0);
        apb(1'b0, ADCS_OFF_CTRL, 32'h0);
        chk(rd, 32'h0000_8031);
        apb(1'b0, ADCS_OFF_IRQST, 32'h0);
        chk(rd, 32'h0000_0003);
        // manual start, then switch the module off while it acquires
        apb(1'b1, ADCS_OFF_CTRL, 32'h0000_8003);
        wait_hi(sample_hold, 8, 1'b1);
        apb(1'b0, ADCS_OFF_CTRL, 32'h0);
        chk(rd, 32'h0000_8003);
        apb(1'b1, ADCS_OFF_CTRL, 32'h0000_0000);
        @(posedge pclk);
        chk({31'h0, sample_hold}, 32'h0);
        apb(1'b0, ADCS_OFF_CTRL, 32'h0);
        chk(rd, 32'h0000_0000);
        chk({31'h0, bad_pair}, 32'h0);
        give_verdict();
    end

    // whole sequence needs under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge pclk);
        errors++;
        give_verdict();
    end
endmodule : adc_sample_convert_control_test
`default_nettype wire
